//--- rtl/dee_access.sv
// data eeprom access controller: registers, unlock checker, self-timed write
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
module dee_access #(
    parameter int POWERUP_CYCLES = dee_pkg::POWERUP_CYCLES,
    parameter int WRITE_CYCLES = dee_pkg::WRITE_CYCLES
) (
    input wire logic clk_sys_i, // system clock
    input wire logic resetn_i, // power-up reset, active low
    input wire logic [7:0] addr_i, // register address
    input wire logic [7:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [7:0] rdata_o, // read data, cycle after rd_i
    output logic [7:0] mem_addr_o, // array location
    output logic [7:0] mem_wdata_o, // array write byte
    output logic mem_we_o, // array write pulse at write end
    input wire logic [7:0] mem_rdata_i, // array byte at mem_addr_o
    output logic irq_o // level interrupt
);
    // enum kept local so the unlock states stay readable
    typedef dee_pkg::dee_unlock_type dee_unlock_type_wrap;
    localparam dee_pkg::dee_unlock_type DEE_IDLE = dee_pkg::DEE_IDLE;
    localparam dee_pkg::dee_unlock_type DEE_GOT_FIRST = dee_pkg::DEE_GOT_FIRST;
    localparam dee_pkg::dee_unlock_type DEE_GOT_SECOND = dee_pkg::DEE_GOT_SECOND;

    logic [7:0] data_byte;
    logic [7:0] location;
    logic enable_bit;
    logic start_bit;
    logic error_bit;
    logic [1:0] flags;
    logic [1:0] mask;
    logic [1:0] gap_cnt;
    dee_unlock_type_wrap unlock_st;
    logic powerup_busy;
    logic [26:0] pu_cnt;
    logic write_busy;
    logic write_done;
    logic [7:0] next_rdata;

    wire hit_data_w = wr_i && (addr_i == dee_pkg::ADDR_DATA);
    wire hit_loc_w = wr_i && (addr_i == dee_pkg::ADDR_LOCATION);
    wire hit_ctl_w = wr_i && (addr_i == dee_pkg::ADDR_CONTROL);
    wire hit_unl_w = wr_i && (addr_i == dee_pkg::ADDR_UNLOCK);
    wire hit_flg_w = wr_i && (addr_i == dee_pkg::ADDR_FLAGS);
    wire hit_msk_w = wr_i && (addr_i == dee_pkg::ADDR_MASK);
    wire read_go_w = hit_ctl_w && wdata_i[dee_pkg::CTL_READ] && !start_bit;
    wire start_req_w = hit_ctl_w && wdata_i[dee_pkg::CTL_START] && !start_bit;
    wire in_time_w = (unlock_st == DEE_GOT_SECOND) && (gap_cnt == dee_pkg::UNLOCK_GAP);
    wire start_ok_w = start_req_w && in_time_w && enable_bit && !powerup_busy;
    wire refuse_w = start_req_w && !start_ok_w;
    wire [1:0] events_w = {refuse_w, write_done};
    wire [7:0] ctl_view_w = {4'h0, error_bit, enable_bit, start_bit, 1'b0};
    wire [7:0] flg_view_w = {6'h00, flags};
    wire [7:0] msk_view_w = {6'h00, mask};

    // power-up timer blocks writes
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pu_cnt <= '0;
            powerup_busy <= 1'b1;
        end else if (powerup_busy) begin
            pu_cnt <= pu_cnt + 27'h1;
            powerup_busy <= (pu_cnt != 27'(POWERUP_CYCLES - 1));
        end
    end

    dee_cycle_timer #(.WIDTH(24)) u_write_timer (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .load_i(start_ok_w),
        .count_i(24'(WRITE_CYCLES)),
        .busy_o(write_busy),
        .done_o(write_done)
    );

    // unlock checker: exact cycle spacing between the three writes
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            unlock_st <= DEE_IDLE;
            gap_cnt <= 2'h0;
        end else if (hit_unl_w) begin
            gap_cnt <= 2'h1;
            if (wdata_i == dee_pkg::UNLOCK_FIRST) begin
                unlock_st <= DEE_GOT_FIRST;
            end else if (wdata_i == dee_pkg::UNLOCK_SECOND && unlock_st == DEE_GOT_FIRST &&
                         gap_cnt == dee_pkg::UNLOCK_GAP) begin
                unlock_st <= DEE_GOT_SECOND;
            end else begin
                unlock_st <= DEE_IDLE;
            end
        end else if (hit_ctl_w) begin
            unlock_st <= DEE_IDLE;
            gap_cnt <= 2'h0;
        end else begin
            case (unlock_st)
                DEE_IDLE: gap_cnt <= 2'h0;
                DEE_GOT_FIRST, DEE_GOT_SECOND: begin
                    if (gap_cnt == dee_pkg::UNLOCK_GAP) begin
                        unlock_st <= DEE_IDLE;
                    end else begin
                        gap_cnt <= gap_cnt + 2'h1;
                    end
                end
                default: unlock_st <= DEE_IDLE;
            endcase
        end
    end

    // data and location registers
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            data_byte <= dee_pkg::RESET_BYTE;
            location <= dee_pkg::RESET_BYTE;
        end else begin
            if (read_go_w) begin
                data_byte <= mem_rdata_i;
            end else if (hit_data_w && !start_bit) begin
                data_byte <= wdata_i;
            end
            if (hit_loc_w && !start_bit) begin
                location <= wdata_i;
            end
        end
    end

    // control bits
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            enable_bit <= 1'b0;
            start_bit <= 1'b0;
            error_bit <= 1'b0;
        end else begin
            if (hit_ctl_w) begin
                enable_bit <= wdata_i[dee_pkg::CTL_ENABLE];
            end
            if (start_ok_w) begin
                start_bit <= 1'b1;
            end else if (write_done) begin
                start_bit <= 1'b0;
            end
            if (refuse_w) begin
                error_bit <= 1'b1;
            end else if (hit_ctl_w && !wdata_i[dee_pkg::CTL_ERROR]) begin
                error_bit <= 1'b0;
            end
        end
    end

    // sticky flags, write one to clear, set wins
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flags <= dee_pkg::RESET_FLAGS;
            mask <= dee_pkg::RESET_FLAGS;
        end else begin
            flags <= (flags & ~(hit_flg_w ? wdata_i[1:0] : 2'h0)) | events_w;
            if (hit_msk_w) begin
                mask <= wdata_i[1:0];
            end
        end
    end

    always_comb begin
        next_rdata = 8'h00;
        case (addr_i)
            dee_pkg::ADDR_DATA: next_rdata = data_byte;
            dee_pkg::ADDR_LOCATION: next_rdata = location;
            dee_pkg::ADDR_CONTROL: next_rdata = ctl_view_w;
            dee_pkg::ADDR_FLAGS: next_rdata = flg_view_w;
            dee_pkg::ADDR_MASK: next_rdata = msk_view_w;
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rdata_o <= 8'h00;
        end else begin
            rdata_o <= rd_i ? next_rdata : 8'h00;
        end
    end

    assign mem_addr_o = location;
    assign mem_wdata_o = data_byte;
    assign mem_we_o = write_done;
    assign irq_o = |(flags & mask);

    // checks
    unlock_timed_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        start_ok_w |-> $past(hit_unl_w, 2) && $past(wdata_i, 2) == dee_pkg::UNLOCK_SECOND)
        else $error("write started without timed unlock");
    enable_needed_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        $rose(start_bit) |-> $past(enable_bit))
        else $error("start bit set with enable clear");
    powerup_block_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        powerup_busy |-> !start_ok_w)
        else $error("write started during power-up");
    read_lands_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        read_go_w |=> data_byte == $past(mem_rdata_i))
        else $error("read byte not in data register");
    data_holds_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !read_go_w && !hit_data_w |=> $stable(data_byte))
        else $error("data register changed unexpectedly");
    start_busy_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        start_bit == write_busy)
        else $error("start bit not matching write in progress");
    done_flag_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        write_done |=> !start_bit && flags[dee_pkg::FLG_DONE])
        else $error("write end did not clear start and set flag");
    flag_sticky_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        flags[dee_pkg::FLG_DONE] && !hit_flg_w |=> flags[dee_pkg::FLG_DONE])
        else $error("complete flag lost");
    enable_kept_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !hit_ctl_w |=> $stable(enable_bit))
        else $error("hardware changed write enable");
    write_runs_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        start_bit && !write_done |=> start_bit)
        else $error("write cut short");
    unlock_reset_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        hit_unl_w && wdata_i != dee_pkg::UNLOCK_FIRST && wdata_i != dee_pkg::UNLOCK_SECOND
        |=> unlock_st == DEE_IDLE)
        else $error("bad unlock value did not reset checker");
    refuse_marks_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        refuse_w |=> flags[dee_pkg::FLG_REFUSED] && error_bit)
        else $error("refused start not flagged");
    gap_bounded_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        gap_cnt <= dee_pkg::UNLOCK_GAP)
        else $error("unlock spacing counter out of range");
    regs_frozen_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        start_bit |=> $stable(location) && $stable(data_byte))
        else $error("location or data changed during write");
    store_busy_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        mem_we_o |-> start_bit)
        else $error("array store outside a write");
    start_end_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        $fell(start_bit) |-> $past(write_done))
        else $error("start bit cleared before write end");
    rdata_idle_a: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
        !rd_i |=> rdata_o == 8'h00)
        else $error("read data not idle");
    write_seen_c: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) start_ok_w);
    unlock_ready_c: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) in_time_w);
    write_done_c: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) write_done);
    refused_c: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) refuse_w);
    read_c: cover property (@(posedge clk_sys_i) disable iff (!resetn_i) read_go_w);
endmodule : dee_access

//--- rtl/dee_pkg.sv
// constants and register map of the data eeprom access controller
package dee_pkg;
    localparam logic [7:0] ADDR_DATA = 8'h9a;
    localparam logic [7:0] ADDR_LOCATION = 8'h9b;
    localparam logic [7:0] ADDR_CONTROL = 8'h9c;
    localparam logic [7:0] ADDR_UNLOCK = 8'h9d;
    localparam logic [7:0] ADDR_FLAGS = 8'ha0;
    localparam logic [7:0] ADDR_MASK = 8'ha1;
    localparam logic [7:0] UNLOCK_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_SECOND = 8'haa;
    // control bit positions
    localparam int CTL_READ = 0;
    localparam int CTL_START = 1;
    localparam int CTL_ENABLE = 2;
    localparam int CTL_ERROR = 3;
    // flag bit positions
    localparam int FLG_DONE = 0;
    localparam int FLG_REFUSED = 1;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] RESET_FLAGS = 2'h0;
    // exact spacing in cycles: first to second unlock write, then second unlock write to start bit write
    localparam logic [1:0] UNLOCK_GAP = 2'h2;
    localparam int CLK_MHZ = 125;
    localparam int POWERUP_MS = 64;
    localparam int POWERUP_CYCLES = POWERUP_MS * 1000 * CLK_MHZ;
    localparam int WRITE_US = 4;
    localparam int WRITE_CYCLES = WRITE_US * CLK_MHZ;
    typedef enum logic [1:0] {
        DEE_IDLE,
        DEE_GOT_FIRST,
        DEE_GOT_SECOND
    } dee_unlock_type;
endpackage : dee_pkg

//--- rtl/dee_cycle_timer.sv
// down counter that raises done when its load count expires
`timescale 1ns/1ps
module dee_cycle_timer #(
    parameter int WIDTH = 24
) (
    input wire logic clk_sys_i, // system clock
    input wire logic resetn_i, // async reset, active low
    input wire logic load_i, // load count and start
    input wire logic [WIDTH-1:0] count_i, // cycles to run
    output logic busy_o, // counting
    output logic done_o // one cycle pulse at expiry
);
    logic [WIDTH-1:0] remain;
    logic running;
    wire last_w = running && (remain == WIDTH'(1));

    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            remain <= '0;
            running <= 1'b0;
        end else if (load_i) begin
            remain <= count_i;
            running <= 1'b1;
        end else if (running) begin
            remain <= remain - WIDTH'(1);
            running <= !last_w;
        end
    end

    assign busy_o = running;
    assign done_o = last_w;
endmodule : dee_cycle_timer

//--- sim/testbench.sv
// self-checking bench for the data eeprom access controller
`timescale 1ns/1ps
module testbench;
    localparam int PU = 20;
    localparam int WC = 16;
    logic clk_sys_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic [7:0] mem_addr_o;
    logic [7:0] mem_wdata_o;
    logic mem_we_o;
    logic [7:0] mem_rdata_i;
    logic irq_o;
    logic [7:0] mem [256];
    logic hit;
    int err_total = 0;
    int cmp_count = 0;
    int we_count = 0;

    dee_access #(.POWERUP_CYCLES(PU), .WRITE_CYCLES(WC)) uut (
        .clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i),
        .addr_i(addr_i),
        .wdata_i(wdata_i),
        .wr_i(wr_i),
        .rd_i(rd_i),
        .rdata_o(rdata_o),
        .mem_addr_o(mem_addr_o),
        .mem_wdata_o(mem_wdata_o),
        .mem_we_o(mem_we_o),
        .mem_rdata_i(mem_rdata_i),
        .irq_o(irq_o)
    );

    always #4 clk_sys_i = ~clk_sys_i;
    // behavioural array behind the controller
    assign mem_rdata_i = mem[mem_addr_o];
    always @(posedge clk_sys_i) begin
        if (mem_we_o === 1'b1) begin
            mem[mem_addr_o] <= mem_wdata_o;
            we_count <= we_count + 1;
        end
    end

    task final_report;
        if (err_total == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", nm, exp, got);
            err_total++;
        end
    endtask : chk

    // strobe stands one cycle, then one idle cycle before the next access
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(posedge clk_sys_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        chk(nm, exp, rdata_o);
    endtask : rd

    task unlock;
        wr(dee_pkg::ADDR_UNLOCK, dee_pkg::UNLOCK_FIRST);
        wr(dee_pkg::ADDR_UNLOCK, dee_pkg::UNLOCK_SECOND);
    endtask : unlock

    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i);
        end
        mem[8'h21] = 8'h5c;
        repeat (10) @(posedge clk_sys_i);
        resetn_i <= 1'b1;
        // reset values and an unmapped place
        rd(dee_pkg::ADDR_DATA, 8'h00, "data reset");
        rd(dee_pkg::ADDR_LOCATION, 8'h00, "location reset");
        rd(dee_pkg::ADDR_CONTROL, 8'h00, "control reset");
        rd(8'h10, 8'h00, "unmapped");
        // start attempt while the power-up timer still runs
        wr(dee_pkg::ADDR_MASK, 8'h02);
        wr(dee_pkg::ADDR_CONTROL, 8'h04);
        unlock();
        wr(dee_pkg::ADDR_CONTROL, 8'h06);
        rd(dee_pkg::ADDR_CONTROL, 8'h0c, "powerup refused");
        chk("irq refused", 8'h01, 8'(irq_o));
        wr(dee_pkg::ADDR_FLAGS, 8'h02);
        wr(dee_pkg::ADDR_MASK, 8'h00);
        #1 chk("irq cleared", 8'h00, 8'(irq_o));
        repeat (PU + 2) @(posedge clk_sys_i);
        // read strobe brings the byte one cycle later and it holds
        wr(dee_pkg::ADDR_LOCATION, 8'h21);
        wr(dee_pkg::ADDR_CONTROL, 8'h01);
        rd(dee_pkg::ADDR_DATA, 8'h5c, "read byte");
        mem[8'h21] <= 8'h3e;
        rd(dee_pkg::ADDR_DATA, 8'h5c, "read held");
        rd(dee_pkg::ADDR_CONTROL, 8'h00, "read bit clears");
        // start without enable
        wr(dee_pkg::ADDR_LOCATION, 8'h30);
        wr(dee_pkg::ADDR_DATA, 8'ha5);
        unlock();
        wr(dee_pkg::ADDR_CONTROL, 8'h02);
        rd(dee_pkg::ADDR_CONTROL, 8'h08, "no enable refused");
        rd(dee_pkg::ADDR_DATA, 8'ha5, "data written");
        // broken unlock: wrong order, wrong value, wrong spacing
        for (int c = 0; c < 3; c++) begin
            wr(dee_pkg::ADDR_CONTROL, 8'h04);
            wr(dee_pkg::ADDR_FLAGS, 8'h02);
            wr(dee_pkg::ADDR_UNLOCK, c == 0 ? 8'haa : 8'h55);
            if (c == 2) @(posedge clk_sys_i);
            wr(dee_pkg::ADDR_UNLOCK, c == 0 ? 8'h55 : (c == 1 ? 8'h12 : 8'haa));
            if (c == 1) wr(dee_pkg::ADDR_UNLOCK, 8'haa);
            wr(dee_pkg::ADDR_CONTROL, 8'h06);
            rd(dee_pkg::ADDR_CONTROL, 8'h0c, "bad unlock refused");
            rd(dee_pkg::ADDR_FLAGS, 8'h02, "refused flag");
        end
        rd(dee_pkg::ADDR_UNLOCK, 8'h00, "unlock reads zero");
        chk("no array write", 8'h00, 8'(we_count));
        // proper write, enable dropped mid-write, mask clear
        wr(dee_pkg::ADDR_FLAGS, 8'h02);
        wr(dee_pkg::ADDR_CONTROL, 8'h04);
        unlock();
        wr(dee_pkg::ADDR_CONTROL, 8'h06);
        wr(dee_pkg::ADDR_CONTROL, 8'h00);
        rd(dee_pkg::ADDR_CONTROL, 8'h02, "start stands");
        wr(dee_pkg::ADDR_DATA, 8'h77);
        hit = 1'b0;
        for (int i = 0; i < 40 && !hit; i++) begin
            @(posedge clk_sys_i);
            #1;
            hit = (mem_we_o === 1'b1);
        end
        if (!hit) begin
            err_total++;
            final_report();
        end
        chk("array location", 8'h30, mem_addr_o);
        chk("array byte", 8'ha5, mem_wdata_o);
        rd(dee_pkg::ADDR_CONTROL, 8'h00, "start cleared");
        rd(dee_pkg::ADDR_FLAGS, 8'h01, "complete flag");
        chk("irq masked", 8'h00, 8'(irq_o));
        wr(dee_pkg::ADDR_MASK, 8'h01);
        #1 chk("irq raised", 8'h01, 8'(irq_o));
        rd(dee_pkg::ADDR_FLAGS, 8'h01, "flag sticky");
        wr(dee_pkg::ADDR_FLAGS, 8'h01);
        #1 chk("irq after clear", 8'h00, 8'(irq_o));
        chk("one array write", 8'h01, 8'(we_count));
        rd(dee_pkg::ADDR_DATA, 8'ha5, "data kept busy");
        wr(dee_pkg::ADDR_CONTROL, 8'h01);
        rd(dee_pkg::ADDR_DATA, 8'ha5, "read back");
        final_report();
    end
endmodule : testbench
